// ===== logic/ccli_pkg.sv
// shared constants and types for the closed caption line inserter
package ccli_pkg;
    // ************************************************************
    // line numbers and field layout
    // ************************************************************
    localparam logic [9:0] ODD_CAPTION_LINE = 10'd21;
    localparam logic [9:0] EVEN_CAPTION_LINE = 10'd284;
    localparam logic [9:0] ODD_LOAD_LINE = 10'd20;
    localparam logic [9:0] EVEN_LOAD_LINE = 10'd283;
    localparam logic [9:0] FIRST_LINE = 10'd1;
    localparam logic [9:0] LINE_RESET = 10'd0;

    // ************************************************************
    // caption waveform timing
    // ************************************************************
    localparam int CLOCK_HZ = 25_000_000;
    localparam int BIT_RATE_HZ = 503_497;
    // bit period in cycles, rounded down so a line never overruns
    localparam logic [7:0] BIT_CYCLES = 8'(CLOCK_HZ / BIT_RATE_HZ);
    localparam logic [7:0] HALF_BIT_CYCLES = 8'(CLOCK_HZ / BIT_RATE_HZ / 2);
    localparam logic [7:0] LINE_START_DELAY_US = 8'd10;
    localparam logic [11:0] START_DELAY_CYCLES = 12'(CLOCK_HZ / 1_000_000 * LINE_START_DELAY_US);
    localparam logic [3:0] RUNIN_CYCLES = 4'd7;
    localparam logic [1:0] GAP_BITS = 2'd2;
    localparam logic [4:0] PAYLOAD_BITS = 5'd16;
    localparam logic [11:0] COUNT_ZERO = 12'h000;
    localparam logic [7:0] BIT_ZERO = 8'h00;

    // ************************************************************
    // output levels and fifo
    // ************************************************************
    localparam logic [9:0] LEVEL_BLANK = 10'h0F0;
    localparam logic [9:0] LEVEL_HIGH = 10'h1F0;
    localparam logic [9:0] LEVEL_MID = 10'h170;
    localparam int FIFO_WIDTH = 10;
    localparam int FIFO_DEPTH = 8;

    typedef enum {
        CCLI_IDLE,
        CCLI_WAIT,
        CCLI_RUNIN,
        CCLI_GAP,
        CCLI_START,
        CCLI_DATA,
        CCLI_TAIL
    } ccli_state_e;
endpackage : ccli_pkg

// ===== logic/ccli_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module ccli_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0] count;
    } ccli_fifo_s;

    ccli_fifo_s st;
    ccli_fifo_s next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic pushNow;
    logic popNow;

    assign inReady = (st.count != (AW+1)'(DEPTH));
    assign outValid = (st.count != '0);
    assign pushNow = inValid && inReady;
    assign popNow = outValid && outReady;
    assign outData = mem[st.rdPtr];

    always_comb begin
        next_st = st;
        if (pushNow) begin
            next_st.wrPtr = (st.wrPtr == AW'(DEPTH - 1)) ? '0 : st.wrPtr + 1'b1;
        end
        if (popNow) begin
            next_st.rdPtr = (st.rdPtr == AW'(DEPTH - 1)) ? '0 : st.rdPtr + 1'b1;
        end
        if (pushNow && !popNow) begin
            next_st.count = st.count + 1'b1;
        end else if (popNow && !pushNow) begin
            next_st.count = st.count - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
        if (pushNow) begin
            mem[st.wrPtr] <= inData;
        end
    end
endmodule : ccli_fifo

// ===== logic/ccli_inserter.sv
// closed caption line inserter: builds the caption waveform on two lines per frame
//
// How it works
// - caption data goes on line 21 of odd fields and line 284 of even fields.
// - each caption line opens with a 10 us blank start delay, then seven square cycles standing in for the sine, locked to the caption bit timing.
// - after the run-in the blank level is held two bit periods, then a start bit of 1.
// - sixteen payload bits follow as two bytes of seven data bits and an odd parity bit.
// - odd fields take bytes from the caption pair, even fields from the extended pair.
// - caption line timing counts from the external lineStart and advances only while the output fifo has room.
// - with captioning enabled, incoming pixels are ignored on the caption lines.
// - each caption byte holder is one byte deep, so only the last write before a caption line of its field goes out.
`timescale 1ns/10ps
module ccli_inserter (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // field timing from the encoder
    input wire logic lineStart,
    input wire logic fieldOdd,
    input wire logic frameStart,
    // caption control and host bytes
    input wire logic captionOddEnable,
    input wire logic captionEvenEnable,
    input wire logic capByte0Write,
    input wire logic capByte1Write,
    input wire logic extByte0Write,
    input wire logic extByte1Write,
    input wire logic [7:0] hostByte,
    // pixel path in
    input wire logic pixelValid,
    output logic pixelReady,
    input wire logic [9:0] pixelData,
    // video path out
    output logic videoValid,
    input wire logic videoReady,
    output logic [9:0] videoData,
    output logic captionActive
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        ccli_pkg::ccli_state_e state;
        logic [9:0] lineNum;
        logic [11:0] cycleCount;
        logic [7:0] bitCount;
        logic [4:0] bitIndex;
        logic [7:0] capByte0;
        logic [7:0] capByte1;
        logic [7:0] extByte0;
        logic [7:0] extByte1;
        logic [15:0] shiftReg;
        logic onCaption;
        logic [9:0] level;
    } ccli_s;

    ccli_s st;
    ccli_s next_st;
    logic [9:0] fifoInData;
    logic fifoInValid;
    logic fifoInReady;
    logic isCaptionLine;
    logic lineEnabled;

    // odd parity lands in bit 7 of each byte
    function automatic logic [7:0] with_parity(input logic [7:0] b);
        with_parity = {~^b[6:0], b[6:0]};
    endfunction : with_parity

    // lineStart opens line lineNum + 1, so compare one ahead
    assign isCaptionLine = !frameStart
        && (st.lineNum + ccli_pkg::FIRST_LINE == (fieldOdd ? ccli_pkg::ODD_CAPTION_LINE
                                                           : ccli_pkg::EVEN_CAPTION_LINE));
    assign lineEnabled = fieldOdd ? captionOddEnable : captionEvenEnable;

    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb begin
        next_st = st;
        // single-deep holders, overwritten in place
        if (capByte0Write) begin
            next_st.capByte0 = hostByte;
        end
        if (capByte1Write) begin
            next_st.capByte1 = hostByte;
        end
        if (extByte0Write) begin
            next_st.extByte0 = hostByte;
        end
        if (extByte1Write) begin
            next_st.extByte1 = hostByte;
        end
        // bit clock runs outside idle and start delay, and only while the fifo can take a sample
        if (st.state != ccli_pkg::CCLI_IDLE && st.state != ccli_pkg::CCLI_WAIT && fifoInReady) begin
            next_st.bitCount = (st.bitCount == ccli_pkg::BIT_CYCLES - 8'd1) ? ccli_pkg::BIT_ZERO
                                                                            : st.bitCount + 8'd1;
        end
        if (frameStart) begin
            next_st.lineNum = ccli_pkg::LINE_RESET;
        end
        if (lineStart) begin
            next_st.lineNum = (frameStart ? ccli_pkg::LINE_RESET : st.lineNum) + ccli_pkg::FIRST_LINE;
        end
        case (st.state)
            ccli_pkg::CCLI_IDLE: begin
                next_st.onCaption = 1'b0;
                if (lineStart && isCaptionLine && lineEnabled) begin
                    next_st.state = ccli_pkg::CCLI_WAIT;
                    next_st.onCaption = 1'b1;
                    next_st.cycleCount = ccli_pkg::COUNT_ZERO;
                    // load bytes captured by the end of the previous line
                    next_st.shiftReg = fieldOdd ? {with_parity(st.capByte1), with_parity(st.capByte0)}
                                                : {with_parity(st.extByte1), with_parity(st.extByte0)};
                end
            end
            ccli_pkg::CCLI_WAIT: begin
                if (fifoInReady) begin
                    next_st.cycleCount = st.cycleCount + 12'd1;
                    if (st.cycleCount == ccli_pkg::START_DELAY_CYCLES - 12'd1) begin
                        next_st.state = ccli_pkg::CCLI_RUNIN;
                        next_st.cycleCount = ccli_pkg::COUNT_ZERO;
                        next_st.bitCount = ccli_pkg::BIT_ZERO;
                    end
                end
            end
            ccli_pkg::CCLI_RUNIN: begin
                if (fifoInReady && st.bitCount == ccli_pkg::BIT_CYCLES - 8'd1) begin
                    next_st.cycleCount = st.cycleCount + 12'd1;
                    if (st.cycleCount == 12'(ccli_pkg::RUNIN_CYCLES - 4'd1)) begin
                        next_st.state = ccli_pkg::CCLI_GAP;
                        next_st.cycleCount = ccli_pkg::COUNT_ZERO;
                    end
                end
            end
            ccli_pkg::CCLI_GAP: begin
                if (fifoInReady && st.bitCount == ccli_pkg::BIT_CYCLES - 8'd1) begin
                    next_st.cycleCount = st.cycleCount + 12'd1;
                    if (st.cycleCount == 12'(ccli_pkg::GAP_BITS - 2'd1)) begin
                        next_st.state = ccli_pkg::CCLI_START;
                    end
                end
            end
            ccli_pkg::CCLI_START: begin
                if (fifoInReady && st.bitCount == ccli_pkg::BIT_CYCLES - 8'd1) begin
                    next_st.state = ccli_pkg::CCLI_DATA;
                    next_st.bitIndex = '0;
                end
            end
            ccli_pkg::CCLI_DATA: begin
                if (fifoInReady && st.bitCount == ccli_pkg::BIT_CYCLES - 8'd1) begin
                    next_st.shiftReg = {1'b0, st.shiftReg[15:1]};
                    next_st.bitIndex = st.bitIndex + 5'd1;
                    if (st.bitIndex == ccli_pkg::PAYLOAD_BITS - 5'd1) begin
                        next_st.state = ccli_pkg::CCLI_TAIL;
                    end
                end
            end
            ccli_pkg::CCLI_TAIL: begin
                // hold blank to the end of the line, pixels still dropped
                if (lineStart) begin
                    next_st.state = ccli_pkg::CCLI_IDLE;
                    next_st.onCaption = 1'b0;
                end
            end
            default: begin
                next_st.state = ccli_pkg::CCLI_IDLE;
            end
        endcase
        // level follows the state being entered, so a fifo stall never skews a sample
        case (next_st.state)
            ccli_pkg::CCLI_RUNIN: begin
                // square approximation of the sine, one cycle per bit period
                next_st.level = (next_st.bitCount < ccli_pkg::HALF_BIT_CYCLES) ? ccli_pkg::LEVEL_HIGH
                                                                                : ccli_pkg::LEVEL_BLANK;
            end
            ccli_pkg::CCLI_START: begin
                next_st.level = ccli_pkg::LEVEL_HIGH;
            end
            ccli_pkg::CCLI_DATA: begin
                // lsb of byte 0 first
                next_st.level = next_st.shiftReg[0] ? ccli_pkg::LEVEL_HIGH : ccli_pkg::LEVEL_BLANK;
            end
            default: begin
                // idle, start delay, gap and tail all sit at blank
                next_st.level = ccli_pkg::LEVEL_BLANK;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st <= '0;
            st.state <= ccli_pkg::CCLI_IDLE;
            st.level <= ccli_pkg::LEVEL_BLANK;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // output mux and buffering
    // ************************************************************
    // pixels are drained and dropped while the caption owns the line
    assign pixelReady = st.onCaption ? 1'b1 : fifoInReady;
    // caption fills every slot of its line, so its timing never waits on pixels
    assign fifoInValid = st.onCaption ? 1'b1 : pixelValid;
    assign fifoInData = st.onCaption ? st.level : pixelData;
    assign captionActive = st.onCaption;

    ccli_fifo #(
        .WIDTH(ccli_pkg::FIFO_WIDTH),
        .DEPTH(ccli_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(fifoInData),
        .outValid(videoValid),
        .outReady(videoReady),
        .outData(videoData)
    );
endmodule : ccli_inserter

// ===== verification/ccli_inserter_assertions.sv
// concurrent checks on the caption line inserter ports
`timescale 1ns/10ps
module ccli_inserter_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // field timing and enables
    input wire logic lineStart,
    input wire logic fieldOdd,
    input wire logic frameStart,
    input wire logic captionOddEnable,
    input wire logic captionEvenEnable,
    // video out
    input wire logic videoValid,
    input wire logic videoReady,
    input wire logic [9:0] videoData,
    input wire logic captionActive
);
    logic [11:0] capCount;
    // cycles the caption has owned the current line
    always_ff @(posedge mclk) begin
        capCount <= (sys_rst || !captionActive) ? 12'h000 : capCount + 12'h001;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    chk_rise_on_line: assert property ($rose(captionActive) |-> $past(lineStart))
        else $error("caption began away from a line start");
    chk_first_line: assert property (lineStart && frameStart |=> !captionActive)
        else $error("caption on first line of a field");
    chk_next_line: assert property (lineStart && captionActive |=> !captionActive)
        else $error("caption ran into the following line");
    chk_odd_off: assert property (lineStart && fieldOdd && !captionOddEnable |=> !captionActive)
        else $error("caption inserted in a disabled odd field");
    chk_even_off: assert property (lineStart && !fieldOdd && !captionEvenEnable |=> !captionActive)
        else $error("caption inserted in a disabled even field");
    chk_fall_on_line: assert property ($fell(captionActive) |-> $past(lineStart))
        else $error("caption released the line early");
    chk_line_length: assert property ($fell(captionActive) |-> capCount >= 12'h5DC)
        else $error("caption line shorter than its waveform");
    chk_stall_hold: assert property (videoValid && !videoReady |=> videoValid && $stable(videoData))
        else $error("video sample lost during a stall");
endmodule : ccli_inserter_checker

bind ccli_inserter ccli_inserter_checker ccli_inserter_checker_i (.mclk, .sys_rst, .lineStart, .fieldOdd,
    .frameStart, .captionOddEnable, .captionEvenEnable, .videoValid, .videoReady, .videoData, .captionActive);

// ===== verification/ccli_host_model.sv
// host model that loads two caption bytes once per field
`timescale 1ns/10ps
module ccli_host_model (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // field timing seen by the host
    input wire logic lineStart,
    input wire logic frameStart,
    input wire logic fieldOdd,
    input wire logic [15:0] nextPair,
    // byte writes
    output logic capByte0Write,
    output logic capByte1Write,
    output logic extByte0Write,
    output logic extByte1Write,
    output logic [7:0] hostByte
);
    logic [9:0] lineNum = 10'h000;
    initial begin
        {capByte0Write, capByte1Write, extByte0Write, extByte1Write} = 4'h0;
        hostByte = 8'h00;
    end
    // load on the line before the caption line, as a vsync-driven host would
    always @(posedge mclk) begin
        if (sys_rst)
            lineNum = 10'h000;
        else if (lineStart)
            lineNum = frameStart ? 10'h001 : lineNum + 10'h001;
        if (lineStart && !sys_rst && lineNum == (fieldOdd ? ccli_pkg::ODD_LOAD_LINE : ccli_pkg::EVEN_LOAD_LINE))
            load(nextPair);
    end
    // whole pair in one field; a junk byte first proves the last write wins
    task automatic load(input logic [15:0] pair);
        #1;
        hostByte = ~pair[7:0];
        capByte0Write = fieldOdd;
        extByte0Write = !fieldOdd;
        @(posedge mclk);
        #1;
        hostByte = pair[7:0];
        @(posedge mclk);
        #1;
        hostByte = pair[15:8];
        {capByte0Write, extByte0Write} = 2'h0;
        capByte1Write = fieldOdd;
        extByte1Write = !fieldOdd;
        @(posedge mclk);
        #1;
        {capByte1Write, extByte1Write} = 2'h0;
        hostByte = ~pair[15:8];
    endtask : load
endmodule : ccli_host_model

// ===== verification/test_closed_caption_line_inserter.sv
// self-checking bench for the caption line inserter
`timescale 1ns/10ps
module test_closed_caption_line_inserter;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic lineStart, fieldOdd, frameStart, captionOddEnable, captionEvenEnable, pixelValid, videoReady;
    logic capByte0Write, capByte1Write, extByte0Write, extByte1Write, pixelReady, videoValid, captionActive;
    logic [7:0] hostByte;
    logic [9:0] pixelData, videoData;
    logic [15:0] nextPair;
    int q[$];
    int badCount = 0;
    int samplesChecked = 0;
    int runinHigh;
    bit capLine = 1'b0;

    ccli_inserter ccli_inserter_i (.mclk, .sys_rst, .lineStart, .fieldOdd, .frameStart, .captionOddEnable,
        .captionEvenEnable, .capByte0Write, .capByte1Write, .extByte0Write, .extByte1Write, .hostByte,
        .pixelValid, .pixelReady, .pixelData, .videoValid, .videoReady, .videoData, .captionActive);
    ccli_host_model ccli_host_model_i (.mclk, .sys_rst, .lineStart, .frameStart, .fieldOdd, .nextPair,
        .capByte0Write, .capByte1Write, .extByte0Write, .extByte1Write, .hostByte);

    always #20 mclk = ~mclk;
    always @(posedge mclk) begin
        #1;
        videoReady = ($urandom_range(3, 0) != 0);
    end
    // pixels taken on a caption line are dropped, elsewhere they pass
    always @(posedge mclk) begin
        if (pixelValid && pixelReady === 1'b1 && !capLine) q.push_back(int'(pixelData));
        if (videoValid === 1'b1 && videoReady) check(videoData);
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic fail(input string msg);
        badCount++;
        $display("FAIL %0t %s", $time, msg);
    endtask : fail
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    // -1 marks a blank tail of unknown length, -2 a run-in sample of either level
    task automatic check(input logic [9:0] v);
        int e;
        if (q.size() > 0 && q[0] == -1) begin
            if (v === ccli_pkg::LEVEL_BLANK) return;
            void'(q.pop_front());
        end
        e = (q.size() > 0) ? q.pop_front() : -3;
        samplesChecked++;
        if (e == -2) begin
            runinHigh += int'(v === ccli_pkg::LEVEL_HIGH);
            e = (v === ccli_pkg::LEVEL_HIGH) ? int'(ccli_pkg::LEVEL_HIGH) : int'(ccli_pkg::LEVEL_BLANK);
        end
        if (e < 0 || v !== e[9:0]) fail("video sample mismatch");
    endtask : check
    task automatic expect_caption(input logic [15:0] pair);
        logic [7:0] b;
        repeat (ccli_pkg::START_DELAY_CYCLES) q.push_back(int'(ccli_pkg::LEVEL_BLANK));
        repeat (int'(ccli_pkg::RUNIN_CYCLES) * ccli_pkg::BIT_CYCLES) q.push_back(-2);
        repeat (int'(ccli_pkg::GAP_BITS) * ccli_pkg::BIT_CYCLES) q.push_back(int'(ccli_pkg::LEVEL_BLANK));
        repeat (ccli_pkg::BIT_CYCLES) q.push_back(int'(ccli_pkg::LEVEL_HIGH));
        for (int i = 0; i < ccli_pkg::PAYLOAD_BITS; i++) begin
            b = (i < 8) ? pair[7:0] : pair[15:8];
            b[7] = ~^b[6:0];
            repeat (ccli_pkg::BIT_CYCLES) q.push_back(int'(b[i % 8] ? ccli_pkg::LEVEL_HIGH : ccli_pkg::LEVEL_BLANK));
        end
        q.push_back(-1);
    endtask : expect_caption
    task automatic drain(input int keep);
        int guard;
        for (guard = 0; q.size() > keep && guard < 4000; guard++) tick(1);
        if (guard == 4000) fail("output stream stalled");
    endtask : drain
    task automatic run_line(input bit first, input bit cap, input logic [15:0] pair);
        int guard;
        lineStart = 1'b1;
        frameStart = first;
        capLine = cap;
        if (cap) expect_caption(pair);
        tick(1);
        {lineStart, frameStart} = 2'h0;
        tick(2);
        repeat (4) begin
            pixelData = 10'($urandom_range(10'h3FC, 10'h100));
            pixelValid = 1'b1;
            @(posedge mclk);
            for (guard = 0; pixelReady !== 1'b1 && guard < 4000; guard++) @(posedge mclk);
            #1;
        end
        pixelValid = 1'b0;
        if (cap) drain(1);
    endtask : run_line
    task automatic run_field(input bit odd, input bit en, input logic [15:0] pair);
        int last;
        last = odd ? ccli_pkg::ODD_CAPTION_LINE : ccli_pkg::EVEN_CAPTION_LINE;
        fieldOdd = odd;
        captionOddEnable = odd & en;
        captionEvenEnable = !odd & en;
        nextPair = pair;
        runinHigh = 0;
        for (int n = 1; n <= last + 1; n++) run_line(n == 1, en && n == last, pair);
        drain(0);
        if (en && (runinHigh < 7 * ccli_pkg::HALF_BIT_CYCLES || runinHigh > 7 * (ccli_pkg::HALF_BIT_CYCLES + 1)))
            fail("run-in duty wrong");
        $display("test done odd=%0d enabled=%0d pair=%h", odd, en, pair);
    endtask : run_field
    task automatic finalReport();
        $display("checked %0d samples, %0d mismatches", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finalReport

    initial begin
        {lineStart, fieldOdd, frameStart, captionOddEnable, captionEvenEnable, pixelValid, videoReady} = 7'h00;
        pixelData = 10'h000;
        nextPair = 16'h0000;
        void'($urandom(32'h0F18BA16));
        tick(2);
        sys_rst = 1'b0;
        run_field(1'b1, 1'b1, 16'($urandom()));
        run_field(1'b1, 1'b0, 16'($urandom()));
        run_field(1'b0, 1'b1, 16'($urandom()));
        run_field(1'b1, 1'b1, 16'h0000);
        run_field(1'b0, 1'b0, 16'($urandom()));
        finalReport();
    end
    initial begin
        repeat (80000) @(posedge mclk);
        fail("watchdog expired");
        finalReport();
    end
endmodule : test_closed_caption_line_inserter
